/* File: logic/spitn_top.sv */
/*
 spi tunnel, deserializer end. forward: regenerates the spi wires for a
 local peripheral from forward frame bits on the recovered pixel clock.
 reverse: samples a local spi controller on core_clk, queues data samples
 and hands at most one sample plus the select state to each back-channel frame.
 assumes: pix_clk is the recovered pixel clock, frame bits and frame
 requests come from link logic in their own domain, mode is static config.
*/
// Behaviour
// - forward: rebuild clock, data and select from frame bits on pixel clock.
// - forward: hold peripheral return data steady while rebuilt clock is high.
// - forward: rebuilt clock comes one pixel cycle after its data.
// - reverse: synchronise local select and clock into the core clock domain.
// - reverse: capture controller data on each active edge of sampled clock unless the queue stays full.
// - reverse: queue captured samples and drain them into back-channel frames.
// - reverse: every back-channel frame reports the current select state.
// - reverse: at most one data sample per back-channel frame.
// - mode 110 selects forward tunnel, 111 selects reverse tunnel.
`timescale 1ns/10ps
module spitn_top #(
  parameter int DEPTH = spitn_pkg::SMP_DEPTH
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire spitn_pkg::spitn_mode_t high_speed_channel_mode,
  input  wire logic                pix_clk,
  input  wire logic                fwd_frm_valid,
  input  wire logic                fwd_frm_sclk,
  input  wire logic                fwd_frm_pico,
  input  wire logic                fwd_frm_cs_n,
  input  wire logic                periph_poci,
  output logic                     tunnel_spi_clock,
  output logic                     tunnel_pico,
  output logic                     tunnel_cs_n,
  output logic                     fwd_poci_bit,
  input  wire logic                ctrl_sclk,
  input  wire logic                ctrl_pico,
  input  wire logic                ctrl_cs_n,
  input  wire logic                bc_frame_req,
  output logic                     bc_frame_valid,
  output logic                     bc_cs_n,
  output logic                     bc_smp_valid,
  output logic                     bc_smp,
  output logic                     rev_overflow
);
  import spitn_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  // a level crosses only once the second and third stages agree
  function automatic logic settle(input logic [2:0] sync, input logic prev);
    settle = (sync[1] == sync[2]) ? sync[2] : prev;
  endfunction : settle

  // queue depth must be a power of two so pointers wrap by themselves
  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] ptr);
    bump = ptr + PTR_W'(1);
  endfunction : bump

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FWD  = 3'b010,
    ST_REV  = 3'b100
  } spitn_state_e;

  // ---------------- core_clk: mode control ----------------
  spitn_state_e st_q, st_d;
  logic         fwd_en_q;

  wire want_fwd = (high_speed_channel_mode == MODE_FWD_SPI);
  wire want_rev = (high_speed_channel_mode == MODE_REV_SPI);
  wire rev_live = (st_q == ST_REV);

  // a mode change passes through idle so the queue is flushed in between
  always_comb begin
    case (st_q)
      ST_IDLE: st_d = want_fwd ? ST_FWD : (want_rev ? ST_REV : ST_IDLE);
      ST_FWD:  st_d = want_fwd ? ST_FWD : ST_IDLE;
      ST_REV:  st_d = want_rev ? ST_REV : ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q     <= ST_IDLE;
      fwd_en_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      fwd_en_q <= (st_d == ST_FWD);
    end
  end

  // ---------------- pix_clk: forward regeneration ----------------
  logic [1:0] pix_rst_q;
  logic [2:0] fwd_sync_q;
  logic       fwd_live_q;
  logic [2:0] poci_sync_q;
  logic       poci_filt_q;
  logic       sclk_dly_q;
  logic       sclk_out_q;
  logic       pico_out_q;
  logic       cs_n_out_q;
  logic       poci_hold_q;

  // release of the pixel-domain reset is re-timed to pix_clk
  always_ff @(posedge pix_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pix_rst_q <= PIX_RST_VAL;
    end else begin
      pix_rst_q <= {pix_rst_q[0], 1'b0};
    end
  end

  wire pix_rst  = pix_rst_q[1];
  wire fwd_live = fwd_live_q;
  wire frm_take = fwd_live && fwd_frm_valid;

  always_ff @(posedge pix_clk or posedge pix_rst) begin
    if (pix_rst) begin
      fwd_sync_q  <= SYNC_RST_LO;
      fwd_live_q  <= 1'b0;
      poci_sync_q <= SYNC_RST_LO;
      poci_filt_q <= DATA_IDLE;
    end else begin
      // the enable comes from core_clk, so it crosses like a pin does
      fwd_sync_q  <= {fwd_sync_q[1:0], fwd_en_q};
      fwd_live_q  <= settle(fwd_sync_q, fwd_live_q);
      poci_sync_q <= {poci_sync_q[1:0], periph_poci};
      poci_filt_q <= settle(poci_sync_q, poci_filt_q);
    end
  end

  // data and select follow the frame; the clock goes through one more stage
  // so the peripheral sees an extra pixel cycle of setup
  always_ff @(posedge pix_clk or posedge pix_rst) begin
    if (pix_rst) begin
      sclk_dly_q  <= SCLK_IDLE;
      sclk_out_q  <= SCLK_IDLE;
      pico_out_q  <= DATA_IDLE;
      cs_n_out_q  <= CS_N_IDLE;
      poci_hold_q <= DATA_IDLE;
    end else if (!fwd_live) begin
      sclk_dly_q  <= SCLK_IDLE;
      sclk_out_q  <= SCLK_IDLE;
      pico_out_q  <= DATA_IDLE;
      cs_n_out_q  <= CS_N_IDLE;
      poci_hold_q <= DATA_IDLE;
    end else begin
      if (frm_take) begin
        sclk_dly_q <= fwd_frm_sclk;
        pico_out_q <= fwd_frm_pico;
        cs_n_out_q <= fwd_frm_cs_n;
      end
      sclk_out_q <= sclk_dly_q;
      if (!sclk_out_q) begin
        poci_hold_q <= poci_filt_q;
      end
    end
  end

  assign tunnel_spi_clock = sclk_out_q;
  assign tunnel_pico      = pico_out_q;
  assign tunnel_cs_n      = cs_n_out_q;
  assign fwd_poci_bit     = poci_hold_q;

  // ---------------- core_clk: reverse sampling and queue ----------------
  logic [2:0]       sclk_sync_q, pico_sync_q, cs_sync_q;
  logic             sclk_filt_q, pico_filt_q, cs_filt_q;
  logic [DEPTH-1:0] smp_mem_q;
  logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic [CNT_W-1:0] cnt_q;
  logic             frm_vld_q, frm_cs_q, smp_vld_q, smp_q, ovf_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_sync_q <= SYNC_RST_LO;
      pico_sync_q <= SYNC_RST_LO;
      cs_sync_q   <= SYNC_RST_HI;
      sclk_filt_q <= SCLK_IDLE;
      pico_filt_q <= DATA_IDLE;
      cs_filt_q   <= CS_N_IDLE;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], ctrl_sclk};
      pico_sync_q <= {pico_sync_q[1:0], ctrl_pico};
      cs_sync_q   <= {cs_sync_q[1:0], ctrl_cs_n};
      sclk_filt_q <= settle(sclk_sync_q, sclk_filt_q);
      pico_filt_q <= settle(pico_sync_q, pico_filt_q);
      cs_filt_q   <= settle(cs_sync_q, cs_filt_q);
    end
  end

  // rising edge is the active one; data takes the same path so it lines up
  wire sclk_rise = rev_live && !sclk_filt_q && settle(sclk_sync_q, sclk_filt_q);
  wire q_empty   = (cnt_q == '0);
  wire q_full    = (cnt_q == CNT_FULL);
  wire pop       = rev_live && bc_frame_req && !q_empty;
  wire push      = sclk_rise && (!q_full || pop);
  wire smp_in    = settle(pico_sync_q, pico_filt_q);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      smp_mem_q <= '0;
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      cnt_q     <= '0;
      ovf_q     <= 1'b0;
    end else if (!rev_live) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
      ovf_q    <= 1'b0;
    end else begin
      if (push) begin
        smp_mem_q[wr_ptr_q] <= smp_in;
        wr_ptr_q            <= bump(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= bump(rd_ptr_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end else if (pop && !push) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
      // a sample lost to a full queue stays flagged until the mode is left
      if (sclk_rise && !push) begin
        ovf_q <= 1'b1;
      end
    end
  end

  // one answer per frame request; select state rides in every frame
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frm_vld_q <= 1'b0;
      frm_cs_q  <= CS_N_IDLE;
      smp_vld_q <= 1'b0;
      smp_q     <= DATA_IDLE;
    end else begin
      frm_vld_q <= rev_live && bc_frame_req;
      frm_cs_q  <= rev_live ? cs_filt_q : CS_N_IDLE;
      smp_vld_q <= pop;
      smp_q     <= pop ? smp_mem_q[rd_ptr_q] : DATA_IDLE;
    end
  end

  assign bc_frame_valid = frm_vld_q;
  assign bc_cs_n        = frm_cs_q;
  assign bc_smp_valid   = smp_vld_q;
  assign bc_smp         = smp_q;
  assign rev_overflow   = ovf_q;

  // ---------------- checks ----------------
  sequence s_fwd_two;
    frm_take ##1 fwd_live;
  endsequence

  property p_fwd_regen;
    @(posedge pix_clk) disable iff (pix_rst)
      frm_take |=> (tunnel_pico == $past(fwd_frm_pico)) && (tunnel_cs_n == $past(fwd_frm_cs_n));
  endproperty
  a_fwd_regen: assert property (p_fwd_regen)
    else $error("forward data or select not rebuilt");

  property p_clk_lag;
    @(posedge pix_clk) disable iff (pix_rst)
      s_fwd_two |=> (tunnel_spi_clock == $past(fwd_frm_sclk, 2));
  endproperty
  a_clk_lag: assert property (p_clk_lag)
    else $error("rebuilt clock not one cycle behind data");

  property p_poci_hold;
    @(posedge pix_clk) disable iff (pix_rst)
      fwd_live && $past(fwd_live) && $past(tunnel_spi_clock) |-> $stable(fwd_poci_bit);
  endproperty
  a_poci_hold: assert property (p_poci_hold)
    else $error("return data moved while clock high");

  property p_idle_lines;
    @(posedge pix_clk) disable iff (pix_rst)
      !fwd_live |=> tunnel_cs_n && !tunnel_spi_clock && !tunnel_pico;
  endproperty
  a_idle_lines: assert property (p_idle_lines) else $error("idle lines not at rest levels");

  property p_sync_settle;
    @(posedge core_clk) disable iff (sys_rst)
      (cs_sync_q[1] == cs_sync_q[2]) |=> (cs_filt_q == $past(cs_sync_q[2]));
  endproperty
  a_sync_settle: assert property (p_sync_settle)
    else $error("select not taken after agreement");

  property p_capture;
    @(posedge core_clk) disable iff (sys_rst)
      push |=> (smp_mem_q[$past(wr_ptr_q)] == $past(smp_in));
  endproperty
  a_capture: assert property (p_capture) else $error("sample not stored on clock edge");

  property p_queue_grow;
    @(posedge core_clk) disable iff (sys_rst)
      rev_live && push && !pop |=> (cnt_q == $past(cnt_q) + CNT_W'(1));
  endproperty
  a_queue_grow: assert property (p_queue_grow) else $error("queue count did not grow");

  sequence s_req_live;
    rev_live && bc_frame_req;
  endsequence

  property p_frame_cs;
    @(posedge core_clk) disable iff (sys_rst)
      s_req_live |=> bc_frame_valid && (bc_cs_n == $past(cs_filt_q));
  endproperty
  a_frame_cs: assert property (p_frame_cs) else $error("frame lacks current select");

  property p_one_sample;
    @(posedge core_clk) disable iff (sys_rst)
      bc_smp_valid |-> bc_frame_valid && ($past(cnt_q) != '0);
  endproperty
  a_one_sample: assert property (p_one_sample) else $error("sample sent outside a frame");

endmodule : spitn_top

/* File: logic/spitn_pkg.sv */
/*
 spi tunnel package: channel mode codes, idle levels, reset values and
 default sizes shared by the tunnel logic.
 assumes nothing beyond a SystemVerilog compiler.
*/
package spitn_pkg;

  typedef logic [2:0] spitn_mode_t;

  // high-speed channel mode codes that open the tunnel
  localparam spitn_mode_t MODE_FWD_SPI = 3'h6;
  localparam spitn_mode_t MODE_REV_SPI = 3'h7;

  // idle levels of the regenerated and reported lines
  localparam logic CS_N_IDLE = 1'h1;
  localparam logic SCLK_IDLE = 1'h0;
  localparam logic DATA_IDLE = 1'h0;

  // synchroniser reset image: select and pixel reset idle high, the rest low
  localparam logic [2:0] SYNC_RST_HI = 3'h7;
  localparam logic [2:0] SYNC_RST_LO = 3'h0;
  localparam logic [1:0] PIX_RST_VAL = 2'h3;

  // default depth of the reverse sample queue (power of two)
  localparam int SMP_DEPTH = 8;

endpackage : spitn_pkg

/* File: verif/spitn_bc_model.sv */
/*
 back-channel framer model: asks for one frame every GAP core cycles while
 enabled and records the select state and the samples each frame brings.
 assumes the core clock domain and the registered frame answer of the tunnel.
*/
`timescale 1ns/10ps
module spitn_bc_model #(
  parameter int GAP = 6
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic en,
  input  wire logic bc_frame_valid,
  input  wire logic bc_cs_n,
  input  wire logic bc_smp_valid,
  input  wire logic bc_smp,
  output logic      bc_frame_req
);
  logic [7:0] cnt_q;
  logic       cs_seen_q;
  logic       smp_q[$];
  int         n_frm;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
      bc_frame_req <= 1'h0;
      cs_seen_q <= 1'h1;
      n_frm <= 0;
    end else begin
      cnt_q <= (cnt_q == 8'(GAP - 1)) ? 8'h00 : cnt_q + 8'h01;
      bc_frame_req <= en && (cnt_q == 8'h00);
      if (bc_frame_valid) begin
        n_frm <= n_frm + 1;
        cs_seen_q <= bc_cs_n;
        // replay may be bursty; order is all that counts
        if (bc_smp_valid) smp_q.push_back(bc_smp);
      end
    end
  end
endmodule : spitn_bc_model

/* File: verif/spitn_top_tb_top.sv */
/*
 testbench of the tunnel: forward frames on the pixel clock, a local spi
 controller in reverse and a back-channel framer model.
 assumes the tunnel's registered outputs and two unrelated clocks.
*/
`timescale 1ns/10ps
module spitn_top_tb_top;
  import spitn_pkg::*;
  localparam int DEPTH = 4;
  localparam int LIMIT = 5000;
  logic        core_clk = 1'h0;
  logic        pix_clk = 1'h0;
  logic        sys_rst = 1'h1;
  spitn_mode_t mode = 3'h0;
  logic        fwd_frm_valid = 1'h0;
  logic        fwd_frm_sclk = 1'h0;
  logic        fwd_frm_pico = 1'h0;
  logic        fwd_frm_cs_n = 1'h1;
  logic        periph_poci = 1'h0;
  logic        ctrl_sclk = 1'h0;
  logic        ctrl_pico = 1'h0;
  logic        ctrl_cs_n = 1'h1;
  logic        en = 1'h0;
  logic        sclk, pico, cs_n, poci, req, fv, bcs, sv, smp, ovf;
  logic [5:0]  rows[7] = '{6'h09, 6'h00, 6'h12, 6'h36, 6'h24, 6'h00, 6'h09};
  logic        bits[6] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1};
  logic        prev = 1'h0;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;

  spitn_top #(.DEPTH(DEPTH)) spitn_top_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .high_speed_channel_mode(mode),
    .pix_clk(pix_clk), .fwd_frm_valid(fwd_frm_valid), .fwd_frm_sclk(fwd_frm_sclk),
    .fwd_frm_pico(fwd_frm_pico), .fwd_frm_cs_n(fwd_frm_cs_n),
    .periph_poci(periph_poci), .tunnel_spi_clock(sclk), .tunnel_pico(pico),
    .tunnel_cs_n(cs_n), .fwd_poci_bit(poci), .ctrl_sclk(ctrl_sclk),
    .ctrl_pico(ctrl_pico), .ctrl_cs_n(ctrl_cs_n), .bc_frame_req(req),
    .bc_frame_valid(fv), .bc_cs_n(bcs), .bc_smp_valid(sv), .bc_smp(smp),
    .rev_overflow(ovf));

  spitn_bc_model #(.GAP(6)) spitn_bc_model_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .en(en), .bc_frame_valid(fv),
    .bc_cs_n(bcs), .bc_smp_valid(sv), .bc_smp(smp), .bc_frame_req(req));

  always #2 core_clk = ~core_clk;
  always #15 pix_clk = ~pix_clk;

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      conclude();
    end
  end

  task automatic cmp(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : cmp

  task automatic pix(input int n);
    repeat (n) @(posedge pix_clk);
    #1;
  endtask : pix

  task automatic core(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : core

  task automatic frame(input logic [2:0] f);
    fwd_frm_valid = 1'h1;
    {fwd_frm_sclk, fwd_frm_pico, fwd_frm_cs_n} = f;
  endtask : frame

  // slow enough that the three-flop synchroniser sees every phase
  task automatic spi_bit(input logic b);
    ctrl_pico = b;
    core(8);
    ctrl_sclk = 1'h1;
    core(8);
    ctrl_sclk = 1'h0;
    core(8);
  endtask : spi_bit

  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  initial begin
    // pixel-domain reset is re-timed, so hold it over several pixel edges
    pix(3);
    sys_rst = 1'h0;
    cmp(cs_n, CS_N_IDLE, "rst cs");
    cmp(sclk, SCLK_IDLE, "rst clk");
    cmp(pico, DATA_IDLE, "rst pico");
    cmp(bcs, 1'h1, "rst bc cs");
    mode = MODE_FWD_SPI;
    pix(8);
    for (int i = 0; i < 7; i++) begin
      frame(rows[i][5:3]);
      pix(1);
      cmp(pico, rows[i][1], "pico");
      cmp(cs_n, rows[i][0], "cs");
      cmp(sclk, prev, "clk lag");
      pix(1);
      cmp(sclk, rows[i][2], "clk");
      prev = rows[i][2];
    end
    frame(3'h0);
    periph_poci = 1'h1;
    pix(8);
    cmp(poci, 1'h1, "poci track");
    frame(3'h4);
    pix(3);
    periph_poci = 1'h0;
    pix(8);
    cmp(poci, 1'h1, "poci hold");
    frame(3'h0);
    pix(8);
    cmp(poci, 1'h0, "poci free");
    mode = 3'h0;
    en = 1'h1;
    pix(6);
    frame(3'h6);
    pix(4);
    cmp(cs_n, CS_N_IDLE, "off cs");
    cmp(sclk, SCLK_IDLE, "off clk");
    cmp(pico, DATA_IDLE, "off pico");
    cmp(spitn_bc_model_inst.n_frm == 0, 1'h1, "off frames");
    fwd_frm_valid = 1'h0;
    core(1);
    en = 1'h0;
    mode = MODE_REV_SPI;
    core(4);
    ctrl_cs_n = 1'h0;
    core(8);
    for (int i = 0; i < 6; i++) spi_bit(bits[i]);
    cmp(ovf, 1'h1, "overflow");
    en = 1'h1;
    core(100);
    cmp(spitn_bc_model_inst.smp_q.size() == DEPTH, 1'h1, "depth");
    for (int i = 0; i < DEPTH; i++)
      cmp(spitn_bc_model_inst.smp_q[i], bits[i], "sample");
    cmp(spitn_bc_model_inst.cs_seen_q, 1'h0, "bc cs low");
    // select stays high well over one frame gap
    ctrl_cs_n = 1'h1;
    core(20);
    cmp(spitn_bc_model_inst.cs_seen_q, 1'h1, "bc cs high");
    mode = 3'h0;
    core(3);
    cmp(ovf, 1'h0, "ovf cleared");
    conclude();
  end
endmodule : spitn_top_tb_top
